/* src/sector_prot_pkg.sv */
// Constants shared by the sector protection and locking logic.
// Assumes a mode 0/3 serial bus framed by an active-low chip select.
package sector_prot_pkg;

  // Command opcodes
  localparam logic [7:0] OP_READ_PROT  = 8'h3C;
  localparam logic [7:0] OP_PROTECT    = 8'h36;
  localparam logic [7:0] OP_UNPROTECT  = 8'h39;
  localparam logic [7:0] OP_WRITE_STAT = 8'h01;

  // Address and sector geometry
  localparam int unsigned ADDR_W    = 24;
  localparam int unsigned SECT_BITS = 7;
  localparam int unsigned N_SECT    = 128;
  localparam int unsigned SECT_LSB  = ADDR_W - SECT_BITS;

  // Bit index positions within a frame, counted from zero
  localparam int unsigned CNT_W = 6;
  localparam logic [5:0] IDX_OP_LAST    = 6'h07;
  localparam logic [5:0] IDX_DATA_FIRST = 6'h08;
  localparam logic [5:0] IDX_DATA_LAST  = 6'h0F;
  localparam logic [5:0] IDX_ADDR_LAST  = 6'h1F;
  localparam logic [5:0] CNT_ADDR_DONE  = 6'h20;
  localparam logic [5:0] CNT_DATA_DONE  = 6'h10;
  localparam logic [5:0] CNT_SAT        = 6'h29;

  // First status byte fields
  localparam int unsigned LOCK_BIT = 7;
  localparam int unsigned GSEL_HI  = 5;
  localparam int unsigned GSEL_LO  = 2;
  localparam logic [3:0] GSEL_UNPROT = 4'h0;
  localparam logic [3:0] GSEL_PROT   = 4'hF;

  // Values after power-up
  localparam logic PROT_RST = 1'b1;
  localparam logic LOCK_RST = 1'b0;

  // Protection summary codes
  localparam logic [1:0] SUM_NONE = 2'h0;
  localparam logic [1:0] SUM_SOME = 2'h1;
  localparam logic [1:0] SUM_ALL  = 2'h3;

endpackage : sector_prot_pkg

/* src/sync_2ff.sv */
// Two flip-flop level synchroniser of configurable width.
// Assumes each bit is a level that stays put long enough to be seen.
`timescale 1ns/1ns
module sync_2ff #(
  parameter int unsigned W       = 1,
  parameter logic        RST_VAL = 1'b0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Only the second stage is visible outside
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{RST_VAL}};
      q      <= {W{RST_VAL}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : sync_2ff

/* src/prot_summary.sv */
// Summary of the per-sector protection map: none, some or all set.
// Assumes a combinational consumer that registers the result.
`timescale 1ns/1ns
module prot_summary (
  input  wire logic [sector_prot_pkg::N_SECT-1:0] prot,
  output logic      [1:0]                         summary
);

  logic any_set;
  logic all_set;

  // Reductions over the whole map
  assign any_set = |prot;
  assign all_set = &prot;
  assign summary = all_set ? sector_prot_pkg::SUM_ALL :
                   any_set ? sector_prot_pkg::SUM_SOME :
                             sector_prot_pkg::SUM_NONE;

endmodule : prot_summary

/* src/sector_protect_lock_logic.sv */
// Sector protection readback and hardware/software locking of the
// protection map and its lock bit, behind a serial command bus.
// Assumes sck stands still outside frames and that cs_n rises only
// while sck is idle; commands execute on core_clk after cs_n rises.
//
// Behaviour
// [RULE1] Read query: opcode then three address bytes
// [RULE2] Repeating FFh or 00h after address
// [RULE3] Host reads past first byte when fast
// [RULE4] Chip select release ends read, floats output
// [RULE5] Release allowed at any bit position
// [RULE6] Readback never carries write-protect level
// [RULE7] Summary bits: all, some or none protected
// [RULE8] Write-protect only gates locking, nothing more
// [RULE9] Hard lock equals pin low and lock
// [RULE10] Hard lock ignores protect, unprotect, status writes
// [RULE11] Clearing lock performs no global operation
// [RULE12] Pin low and locked: only power cycle
// [RULE13] Power-up: all protected, lock bit clear
// [RULE14] Pin high still allows setting lock
// [RULE15] Setting lock may include global operation
// [RULE16] Soft lock: clear allowed, sector commands ignored
// [RULE17] Lock clear: everything accepted, lock settable
// [RULE18] Register value one means sector protected
// [RULE19] Global select: zeros unprotect, ones protect
// [RULE20] Only lock bit stored from status byte
// [RULE21] Sector picked by upper address bits
`timescale 1ns/1ns
module sector_protect_lock_logic (
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  input  wire logic                              sck,
  input  wire logic                              cs_n,
  input  wire logic                              si,
  input  wire logic                              wp_n,
  output logic                                   so,
  output logic                                   so_oe_n,
  output logic [sector_prot_pkg::N_SECT-1:0]     prot_map,
  output logic                                   prot_regs_lock_bit,
  output logic [1:0]                             soft_prot_summary_bits,
  output logic                                   wp_level,
  output logic                                   hw_locked
);

  // ---------------------------------------------------------------
  // Serial clock domain
  // ---------------------------------------------------------------

  logic                                 frame_open_q;
  logic [sector_prot_pkg::CNT_W-1:0]    cnt_q;
  logic [sector_prot_pkg::CNT_W-1:0]    cnt_d;
  logic [sector_prot_pkg::CNT_W-1:0]    idx;
  logic [6:0]                           sh_q;
  logic [7:0]                           op_q;
  logic [sector_prot_pkg::ADDR_W-1:0]   addr_q;
  logic [7:0]                           stat_q;
  logic [sector_prot_pkg::N_SECT-1:0]   prot_sck;
  logic [sector_prot_pkg::SECT_BITS-1:0] rd_sect;
  logic                                 rd_bit;
  logic                                 in_op;
  logic                                 in_addr;
  logic                                 in_data;
  logic                                 rd_phase;
  logic                                 so_q;
  logic                                 so_oe_n_q;

  // Frame marker cleared while chip select is high; the first edge of a
  // frame then restarts the bit index without needing a clock at the end
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      frame_open_q <= 1'b0;
    end else begin
      frame_open_q <= 1'b1;
    end
  end

  // Bit index of the bit now arriving, saturating past the longest command
  assign idx     = frame_open_q ? cnt_q : '0;
  assign cnt_d   = (idx == sector_prot_pkg::CNT_SAT) ? idx : idx + 6'h01;
  assign in_op   = (idx <= sector_prot_pkg::IDX_OP_LAST);
  assign in_addr = (idx >= sector_prot_pkg::IDX_DATA_FIRST) &&
                   (idx <= sector_prot_pkg::IDX_ADDR_LAST);
  assign in_data = (idx >= sector_prot_pkg::IDX_DATA_FIRST) &&
                   (idx <= sector_prot_pkg::IDX_DATA_LAST);

  // Capture registers keep their value after the frame so the core side
  // can read them while sck is idle
  always_ff @(posedge sck) begin
    cnt_q <= cnt_d;
    sh_q  <= {sh_q[5:0], si};
  end

  // Opcode is the first byte of the frame
  always_ff @(posedge sck) begin
    if (idx == sector_prot_pkg::IDX_OP_LAST) begin
      op_q <= {sh_q, si}; // RULE1
    end
  end

  // Three address bytes follow the opcode
  always_ff @(posedge sck) begin
    if (in_addr) begin
      addr_q <= {addr_q[sector_prot_pkg::ADDR_W-2:0], si}; // RULE1
    end
  end

  // The first data byte doubles as the status byte of a status write
  always_ff @(posedge sck) begin
    if (in_data) begin
      stat_q <= {stat_q[6:0], si};
    end
  end

  // Protection map brought into the sck domain; it only changes between
  // frames, so two sck edges settle it long before the read phase
  sync_2ff #(
    .W       (sector_prot_pkg::N_SECT),
    .RST_VAL (1'b0)
  ) u_prot_sync (
    .clk (sck),
    .rst (1'b0),
    .d   (prot_map),
    .q   (prot_sck)
  );

  // Selected sector bit; the write-protect pin plays no part here
  assign rd_sect  = addr_q[sector_prot_pkg::ADDR_W-1:sector_prot_pkg::SECT_LSB]; // RULE21
  assign rd_bit   = prot_sck[rd_sect]; // RULE6 RULE18
  assign rd_phase = frame_open_q &&
                    (op_q == sector_prot_pkg::OP_READ_PROT) &&
                    (cnt_q >= sector_prot_pkg::CNT_ADDR_DONE);

  // Output launched on the falling edge so it is stable at the next rise.
  // A constant bit on every clock is the repeating all-ones or all-zeros
  // byte; releasing chip select floats the pin at once, mid-byte or not
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_q      <= 1'b0; // RULE4 RULE5
      so_oe_n_q <= 1'b1; // RULE4
    end else if (rd_phase) begin
      so_q      <= rd_bit; // RULE2
      so_oe_n_q <= 1'b0; // RULE2
    end else begin
      so_q      <= 1'b0;
      so_oe_n_q <= 1'b1;
    end
  end

  assign so      = so_q;
  assign so_oe_n = so_oe_n_q;

  // ---------------------------------------------------------------
  // Core clock domain
  // ---------------------------------------------------------------

  logic                                  cs_s;
  logic                                  cs_d_q;
  logic                                  wp_s;
  logic                                  frame_end;
  logic [sector_prot_pkg::N_SECT-1:0]    prot_q;
  logic [sector_prot_pkg::N_SECT-1:0]    prot_d;
  logic                                  lock_q;
  logic                                  lock_d;
  logic [1:0]                            sum_q;
  logic [1:0]                            sum_w;
  logic                                  hw_lock_q;
  logic                                  wp_level_q;
  logic                                  hw_lock;
  logic                                  soft_lock;
  logic [sector_prot_pkg::SECT_BITS-1:0] cmd_sect;
  logic [3:0]                            gsel;
  logic                                  new_lock;
  logic                                  addr_ok;
  logic                                  data_ok;
  logic                                  do_prot;
  logic                                  do_unprot;
  logic                                  do_wstat;
  logic                                  do_gprot;
  logic                                  do_gunprot;

  // Chip select and write-protect pins synchronised before use
  sync_2ff #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (cs_n),
    .q   (cs_s)
  );

  sync_2ff #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_wp_sync (
    .clk (core_clk),
    .rst (rst),
    .d   (wp_n),
    .q   (wp_s)
  );

  // Edge history of the synchronised chip select
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_d_q <= 1'b1;
    end else begin
      cs_d_q <= cs_s;
    end
  end

  // End of frame; the sck capture registers are frozen by then since the
  // host stops sck before releasing chip select
  assign frame_end = cs_s && !cs_d_q;

  // Lock qualification; the pin alone never touches the map
  assign hw_lock   = !wp_s && lock_q; // RULE9 RULE8
  assign soft_lock = wp_s && lock_q;

  // Command decode from the captured frame
  assign cmd_sect  = addr_q[sector_prot_pkg::ADDR_W-1:sector_prot_pkg::SECT_LSB]; // RULE21
  assign addr_ok   = (cnt_q >= sector_prot_pkg::CNT_ADDR_DONE);
  assign data_ok   = (cnt_q >= sector_prot_pkg::CNT_DATA_DONE);
  assign gsel      = stat_q[sector_prot_pkg::GSEL_HI:sector_prot_pkg::GSEL_LO];
  assign new_lock  = stat_q[sector_prot_pkg::LOCK_BIT]; // RULE20

  // Any set lock bit blocks sector commands, hard or soft
  assign do_prot   = frame_end && addr_ok && !lock_q &&
                     (op_q == sector_prot_pkg::OP_PROTECT); // RULE10 RULE16 RULE17
  assign do_unprot = frame_end && addr_ok && !lock_q &&
                     (op_q == sector_prot_pkg::OP_UNPROTECT); // RULE10 RULE16 RULE17

  // Status writes are refused outright under hardware lock
  assign do_wstat  = frame_end && data_ok && !hw_lock &&
                     (op_q == sector_prot_pkg::OP_WRITE_STAT); // RULE10 RULE12

  // Global operations only from an unlocked state, so clearing the lock
  // in the same write never touches the map
  assign do_gprot   = do_wstat && !lock_q &&
                      (gsel == sector_prot_pkg::GSEL_PROT); // RULE19 RULE15 RULE11
  assign do_gunprot = do_wstat && !lock_q &&
                      (gsel == sector_prot_pkg::GSEL_UNPROT); // RULE19 RULE15 RULE11

  // Next protection map: global operations first, then single sectors
  always_comb begin
    prot_d = prot_q;
    if (do_gprot) begin
      prot_d = {sector_prot_pkg::N_SECT{1'b1}};
    end else if (do_gunprot) begin
      prot_d = '0;
    end else if (do_prot) begin
      prot_d[cmd_sect] = 1'b1; // RULE18
    end else if (do_unprot) begin
      prot_d[cmd_sect] = 1'b0; // RULE18
    end
  end

  // Next lock bit: from unlocked it may go to one, from soft lock it may
  // drop to zero; under hard lock do_wstat never fires
  always_comb begin
    lock_d = lock_q;
    if (do_wstat && !lock_q) begin
      lock_d = new_lock; // RULE14 RULE17
    end else if (do_wstat && soft_lock) begin
      lock_d = new_lock; // RULE16
    end
  end

  // Power-up leaves every sector protected but nothing locked
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prot_q <= {sector_prot_pkg::N_SECT{sector_prot_pkg::PROT_RST}}; // RULE13
      lock_q <= sector_prot_pkg::LOCK_RST; // RULE13
    end else begin
      prot_q <= prot_d;
      lock_q <= lock_d;
    end
  end

  // Summary of how much of the map is set
  prot_summary u_summary (
    .prot    (prot_q),
    .summary (sum_w)
  );

  // Status outputs registered so every port leaves a flip-flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sum_q      <= sector_prot_pkg::SUM_ALL;
      hw_lock_q  <= 1'b0;
      wp_level_q <= 1'b1;
    end else begin
      sum_q      <= sum_w; // RULE7
      hw_lock_q  <= hw_lock;
      wp_level_q <= wp_s;
    end
  end

  assign prot_map               = prot_q;
  assign prot_regs_lock_bit     = lock_q;
  assign soft_prot_summary_bits = sum_q;
  assign hw_locked              = hw_lock_q;
  assign wp_level               = wp_level_q;

endmodule : sector_protect_lock_logic

/* bench/sector_prot_assertions.sv */
// Concurrent checks on the protection, summary and locking outputs.
// Assumes frames are spaced so that commands land while cs_n is high.
`timescale 1ns/1ns
module sector_prot_assertions #(
  parameter int N = sector_prot_pkg::N_SECT
) (
  input wire logic         core_clk,
  input wire logic         rst,
  input wire logic         cs_n,
  input wire logic         wp_n,
  input wire logic         so_oe_n,
  input wire logic [N-1:0] prot_map,
  input wire logic         prot_regs_lock_bit,
  input wire logic [1:0]   soft_prot_summary_bits,
  input wire logic         wp_level,
  input wire logic         hw_locked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // State moves only after a frame ends, never straight from the pin
  map_at_rest_a: assert property (
    !$stable(prot_map) || !$stable(prot_regs_lock_bit) |-> cs_n && $past(cs_n))
    else $error("protection state moved inside a frame");
  // A lock bit already set keeps the map still, also on the clearing write
  locked_map_a: assert property (
    $past(prot_regs_lock_bit) |-> $stable(prot_map))
    else $error("map changed while locked");
  hw_lock_bit_a: assert property (
    hw_locked && $past(hw_locked) |-> $stable(prot_regs_lock_bit))
    else $error("lock bit changed under hardware lock");
  lock_stuck_a: assert property (
    $past(prot_regs_lock_bit) && !wp_level && !$past(wp_level) |-> prot_regs_lock_bit)
    else $error("lock bit cleared with pin low");
  // Two cycles of a steady cause allow for the output register
  hw_on_a: assert property (
    (!wp_level && prot_regs_lock_bit)[*2] |-> hw_locked)
    else $error("hardware lock not shown");
  hw_off_a: assert property (
    (wp_level || !prot_regs_lock_bit)[*2] |-> !hw_locked)
    else $error("hardware lock shown wrongly");
  wp_sync_a: assert property (
    !wp_n[*5] |-> !wp_level)
    else $error("pin level not followed");
  // Summary trails the map by one cycle
  sum_all_a: assert property (
    &$past(prot_map) |-> soft_prot_summary_bits == sector_prot_pkg::SUM_ALL)
    else $error("summary not all");
  sum_none_a: assert property (
    !(|$past(prot_map)) |-> soft_prot_summary_bits == sector_prot_pkg::SUM_NONE)
    else $error("summary not none");
  sum_some_a: assert property (
    |$past(prot_map) && !(&$past(prot_map))
    |-> soft_prot_summary_bits == sector_prot_pkg::SUM_SOME)
    else $error("summary not some");
  oe_off_a: assert property (cs_n |-> so_oe_n) else $error("output driven while deselected");
endmodule // sector_prot_assertions

bind sector_protect_lock_logic sector_prot_assertions #(.N(sector_prot_pkg::N_SECT)) chk (
  .core_clk(core_clk), .rst(rst), .cs_n(cs_n), .wp_n(wp_n), .so_oe_n(so_oe_n),
  .prot_map(prot_map), .prot_regs_lock_bit(prot_regs_lock_bit),
  .soft_prot_summary_bits(soft_prot_summary_bits), .wp_level(wp_level), .hw_locked(hw_locked));

/* bench/spi_host_model.sv */
// Serial host model: mode 0 frames at a 6 ns link period.
// Frames are spaced by 60 ns within the model; sck stands low outside frames.
`timescale 1ns/1ns
module spi_host_model (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input wire logic  so,
  input wire logic  so_oe_n
);
  // A clean rising chip select at start clears the frame and output flops,
  // which have no other reset; it falls inside the core reset
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
    #1 cs_n = 1'b1;
  end

  // Shift nb bits of w MSB first, then clock rd more bits in from so
  task automatic xfer(input int nb, input logic [31:0] w, input int rd,
                      output logic [7:0] got);
    got = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < nb + rd; i++) begin
      si = (i < nb) ? w[31-i] : ~si;
      #3 sck = 1'b1;
      // Keep only the latest byte: the first one may be unusable when fast
      if (i >= nb) got = {got[6:0], (so_oe_n === 1'b0) ? so : 1'bx};
      #3 sck = 1'b0;
    end
    #3 cs_n = 1'b1;
    si = ~si; // Released line must not look like held data
    #60;
  endtask
endmodule // spi_host_model

/* bench/sector_protect_lock_logic_tb_top.sv */
// Self-checking bench for the sector protection and locking block.
// Assumes spi_host_model drives the link and the checker is bound in.
`timescale 1ns/1ns
module sector_protect_lock_logic_tb_top;
  localparam logic [127:0] ONES = {128{1'b1}};
  localparam logic [127:0] M2   = 128'h4;
  logic         core_clk   = 1'b0;
  logic         rst        = 1'b1;
  logic         wp_n       = 1'b1;
  wire          sck;
  wire          cs_n;
  wire          si;
  logic         so;
  logic         so_oe_n;
  logic [127:0] prot_map;
  logic         lock;
  logic [1:0]   sum;
  logic         hw_locked;
  logic         wp_lvl;
  logic [7:0]   got;
  int           err_total  = 0;
  int           n_compared = 0;

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  sector_protect_lock_logic dut (
    .core_clk(core_clk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n),
    .so(so), .so_oe_n(so_oe_n), .prot_map(prot_map), .prot_regs_lock_bit(lock),
    .soft_prot_summary_bits(sum), .wp_level(wp_lvl), .hw_locked(hw_locked));
  spi_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic st(input logic [127:0] m, input logic l);
    check("map", prot_map, m);
    check("lock bit", lock, l);
  endtask

  function automatic logic [23:0] sa(input logic [6:0] s);
    return {s, 17'h0ABCD}; // Any offset inside the sector
  endfunction

  task automatic cmd(input logic [7:0] op, input logic [6:0] s);
    host.xfer(32, {op, sa(s)}, 0, got);
  endtask

  task automatic wst(input logic [7:0] b);
    host.xfer(16, {sector_prot_pkg::OP_WRITE_STAT, b, 16'h0000}, 0, got);
  endtask

  task automatic rdp(input logic [6:0] s, input logic [7:0] exp);
    host.xfer(32, {sector_prot_pkg::OP_READ_PROT, sa(s) ^ 24'h01234}, 16, got);
    check("readback", got, exp);
  endtask

  task automatic set_wp(input logic v);
    @(negedge core_clk) wp_n = v;
    repeat (6) @(negedge core_clk);
    check("pin level", wp_lvl, v);
  endtask

  // Six cycles of reset stand in for a power cycle
  task automatic do_reset();
    @(negedge core_clk) rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask

  task automatic t_power();
    st(ONES, 1'b0);
    check("summary", sum, sector_prot_pkg::SUM_ALL);
    check("hard lock", hw_locked, 1'b0);
    rdp(7'h05, 8'hFF);
  endtask

  task automatic t_sector();
    cmd(sector_prot_pkg::OP_UNPROTECT, 7'h09);
    st(ONES ^ (128'h1 << 9), 1'b0);
    check("summary", sum, sector_prot_pkg::SUM_SOME);
    rdp(7'h09, 8'h00);
    rdp(7'h0A, 8'hFF);
    host.xfer(32, {sector_prot_pkg::OP_READ_PROT, sa(7'h09)}, 5, got);
    check("output enable", so_oe_n, 1'b1);
    rdp(7'h09, 8'h00);
    cmd(sector_prot_pkg::OP_PROTECT, 7'h09);
    st(ONES, 1'b0);
  endtask

  task automatic t_global();
    logic [7:0] b [4] = '{8'h00, 8'h44, 8'h7F, 8'h08};
    logic       e [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wst(b[i]);
      st(e[i] ? ONES : '0, 1'b0);
      check("summary", sum, e[i] ? sector_prot_pkg::SUM_ALL : sector_prot_pkg::SUM_NONE);
    end
  endtask

  task automatic t_soft();
    wst(8'h80);
    st('0, 1'b1);
    cmd(sector_prot_pkg::OP_PROTECT, 7'h03);
    st('0, 1'b1);
    wst(8'h3C);
    st('0, 1'b0);
    check("hard lock", hw_locked, 1'b0);
  endtask

  task automatic t_hard();
    cmd(sector_prot_pkg::OP_PROTECT, 7'h02);
    wst(8'hF0);
    st(M2, 1'b1);
    set_wp(1'b0);
    check("hard lock", hw_locked, 1'b1);
    st(M2, 1'b1);
    wst(8'h00);
    cmd(sector_prot_pkg::OP_UNPROTECT, 7'h02);
    st(M2, 1'b1);
    rdp(7'h02, 8'hFF);
    rdp(7'h04, 8'h00);
    set_wp(1'b1);
    check("hard lock", hw_locked, 1'b0);
    wst(8'h0F);
    st(M2, 1'b0);
    set_wp(1'b0);
    cmd(sector_prot_pkg::OP_UNPROTECT, 7'h02);
    wst(8'h80);
    st('0, 1'b1);
    do_reset();
    st(ONES, 1'b0);
    check("hard lock", hw_locked, 1'b0);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs some 6 us; a hang is cut well beyond that
  initial begin
    #200000;
    err_total++;
    stop_test();
  end

  initial begin
    do_reset();
    t_power();
    t_sector();
    t_global();
    t_soft();
    t_hard();
    stop_test();
  end
endmodule // sector_protect_lock_logic_tb_top
